// [core/tcc_top.sv]
// Two-channel capture/compare/PWM block with modulo counter and byte registers
`default_nettype none
module tcc_top
    import tcc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic tick,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic [1:0] pin_in,
    output logic [1:0] pin_out,
    output logic [1:0] pin_oe,
    output logic [1:0] ch_irq,
    output logic ovf_irq
);
    tcc_state_s r;
    tcc_state_s next_r;

    // Channel control byte as software sees it
    function automatic logic [7:0] ctl_byte(input tcc_ch_s c);
        logic [7:0] b;
        b = 8'h00;
        b[CC_FLAG] = c.flag;
        b[CC_IE] = c.ie;
        b[CC_MSB] = c.msb;
        b[CC_MSA] = c.msa;
        b[CC_ELS +: 2] = c.els;
        b[CC_TOV] = c.tov;
        b[CC_MAX] = c.max;
        return b;
    endfunction

    logic wrap;
    logic cnt_rst;
    logic en;
    logic cap;
    logic cmp;
    logic edge_hit;
    logic match;
    logic ev;
    logic [1:0] evs;
    logic [15:0] cmpv;
    logic buf_on;
    logic [3:0] ctl_ofs;
    logic [3:0] hi_ofs;
    logic [3:0] lo_ofs;

    // Next-state logic: counter, channels, then bus accesses
    always_comb
    begin
        next_r = r;
        next_r.rdata = 8'h00;
        evs = 2'b00;
        en = 1'b0;
        cap = 1'b0;
        cmp = 1'b0;
        edge_hit = 1'b0;
        match = 1'b0;
        ev = 1'b0;
        cmpv = 16'h0000;
        ctl_ofs = OFS_CH0_CTL;
        hi_ofs = OFS_CH0_H;
        lo_ofs = OFS_CH0_L;
        buf_on = r.ch[0].msb;
        cnt_rst = wr && addr == OFS_STATUS && wdata[ST_CRST];
        wrap = tick && !r.stop && r.cnt == r.modv;
        // Counter holds while stopped; wraps to zero at modulo
        if (tick && !r.stop)
        begin
            if (wrap)
            begin
                next_r.cnt = 16'h0000;
            end
            else
            begin
                next_r.cnt = r.cnt + 16'h0001;
            end
        end
        if (cnt_rst)
        begin
            next_r.cnt = 16'h0000;
        end
        // Buffered compare swaps its active register only at period end
        if (wrap && buf_on)
        begin
            next_r.act = r.lastw;
        end
        for (int i = 0; i < 2; i++)
        begin
            // Channel 1 is idle while channel 0 runs buffered
            en = r.ch[i].els != ELS_OFF && !(i == 1 && buf_on);
            cmp = en && (r.ch[i].msa || (i == 0 && buf_on));
            cap = en && !cmp;
            edge_hit = 1'b0;
            unique case (r.ch[i].els)
                ELS_A: edge_hit = pin_in[i] && !r.ch[i].prev;
                ELS_B: edge_hit = !pin_in[i] && r.ch[i].prev;
                ELS_OFF: edge_hit = 1'b0;
                default: edge_hit = pin_in[i] != r.ch[i].prev;
            endcase
            cmpv = (i == 0 && buf_on) ? r.ch[r.act].val : r.ch[i].val;
            match = cmp && tick && !r.stop && r.cnt == cmpv && !r.ch[i].hold;
            ev = match;
            next_r.ch[i].prev = pin_in[i];
            // Captures are dropped while the counter is stopped or while a high-byte read still waits for its low-byte read
            if (cap && edge_hit && !r.stop && !r.ch[i].hold)
            begin
                next_r.ch[i].val = r.cnt;
                ev = 1'b1;
            end
            if (!en)
            begin
                next_r.ch[i].outl = !r.ch[i].msa;
            end
            else if (cmp && wrap && r.ch[i].tov)
            begin
                // Overflow wins over a same-cycle match
                next_r.ch[i].outl = r.ch[i].maxe ? 1'b1 : !r.ch[i].outl;
            end
            else if (match && !(r.ch[i].tov && r.ch[i].maxe))
            begin
                unique case (r.ch[i].els)
                    ELS_A: next_r.ch[i].outl = !r.ch[i].outl;
                    ELS_B: next_r.ch[i].outl = 1'b0;
                    default: next_r.ch[i].outl = 1'b1;
                endcase
            end
            // Max duty is sampled at period boundaries to avoid runt pulses
            if (wrap)
            begin
                next_r.ch[i].maxe = r.ch[i].max;
            end
            next_r.ch[i].val = next_r.ch[i].val;
            evs[i] = ev;
        end
        // Bus reads, with the side effects of arming and byte holds
        if (rd)
        begin
            unique case (addr)
                OFS_STATUS:
                begin
                    next_r.rdata[ST_OVF] = r.ovf;
                    next_r.rdata[ST_OVIE] = r.ovie;
                    next_r.rdata[ST_STOP] = r.stop; // reset bit reads zero
                    next_r.ovarm = r.ovf;
                end
                OFS_CNT_H: next_r.rdata = r.cnt[15:8];
                OFS_CNT_L: next_r.rdata = r.cnt[7:0];
                OFS_MOD_H: next_r.rdata = r.modv[15:8];
                OFS_MOD_L: next_r.rdata = r.modv[7:0];
                default: next_r.rdata = 8'h00;
            endcase
        end
        for (int i = 0; i < 2; i++)
        begin
            ctl_ofs = (i == 0) ? OFS_CH0_CTL : OFS_CH1_CTL;
            hi_ofs = (i == 0) ? OFS_CH0_H : OFS_CH1_H;
            lo_ofs = (i == 0) ? OFS_CH0_L : OFS_CH1_L;
            cap = r.ch[i].els != ELS_OFF && !r.ch[i].msa && !r.ch[i].msb;
            if (rd && addr == ctl_ofs)
            begin
                next_r.rdata = ctl_byte(r.ch[i]);
                next_r.ch[i].armed = r.ch[i].flag;
            end
            if (rd && addr == hi_ofs)
            begin
                next_r.rdata = r.ch[i].val[15:8];
                next_r.ch[i].hold = r.ch[i].hold || cap;
            end
            if (rd && addr == lo_ofs)
            begin
                next_r.rdata = r.ch[i].val[7:0];
                if (cap)
                begin
                    next_r.ch[i].hold = 1'b0;
                end
            end
            if (wr && addr == hi_ofs)
            begin
                next_r.ch[i].val[15:8] = wdata;
                next_r.ch[i].hold = !cap;
            end
            if (wr && addr == lo_ofs)
            begin
                next_r.ch[i].val[7:0] = wdata;
                next_r.ch[i].hold = 1'b0;
                next_r.lastw = i[0];
            end
            // Channel 1 control ignores writes while buffering is on
            if (wr && addr == ctl_ofs && !(i == 1 && buf_on))
            begin
                next_r.ch[i].ie = wdata[CC_IE];
                next_r.ch[i].msb = (i == 0) ? wdata[CC_MSB] : 1'b0;
                next_r.ch[i].msa = wdata[CC_MSA];
                next_r.ch[i].els = wdata[CC_ELS +: 2];
                next_r.ch[i].tov = wdata[CC_TOV];
                next_r.ch[i].max = wdata[CC_MAX];
                next_r.ch[i].armed = 1'b0;
                if (!wdata[CC_FLAG] && r.ch[i].armed)
                begin
                    next_r.ch[i].flag = 1'b0;
                end
            end
            // A new event beats a same-cycle clear and disarms it
            if (evs[i])
            begin
                next_r.ch[i].flag = 1'b1;
                next_r.ch[i].armed = 1'b0;
            end
            next_r.irq[i] = next_r.ch[i].flag && next_r.ch[i].ie;
            next_r.poe[i] = r.ch[i].els != ELS_OFF && !(i == 1 && buf_on);
            next_r.pout[i] = next_r.ch[i].outl;
        end
        // Status and modulo writes
        if (wr && addr == OFS_STATUS)
        begin
            next_r.ovie = wdata[ST_OVIE];
            next_r.stop = wdata[ST_STOP];
            next_r.ovarm = 1'b0;
            if (!wdata[ST_OVF] && r.ovarm)
            begin
                next_r.ovf = 1'b0;
            end
        end
        if (wr && addr == OFS_MOD_H)
        begin
            next_r.modv[15:8] = wdata;
            next_r.minh = 1'b1;
        end
        if (wr && addr == OFS_MOD_L)
        begin
            next_r.modv[7:0] = wdata;
            next_r.minh = 1'b0;
        end
        if (wrap && !r.minh)
        begin
            next_r.ovf = 1'b1;
            next_r.ovarm = 1'b0;
        end
        next_r.ovirq = next_r.ovf && next_r.ovie && !next_r.minh;
    end

    // State register; value registers get a plain zero although undefined
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            r <= '0;
            r.modv <= MOD_RESET;
            r.stop <= STOP_RESET;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign rdata = r.rdata;
    assign pin_out = r.pout;
    assign pin_oe = r.poe;
    assign ch_irq = r.irq;
    assign ovf_irq = r.ovirq;

    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    wrap_zero_a: assert property (wrap && !cnt_rst |=> r.cnt == 16'h0000)
        else $error("counter did not restart at modulo");
    mod_hold_a: assert property (r.minh && !(wr && addr == OFS_MOD_L) |=> !$rose(r.ovf))
        else $error("overflow flag set while modulo half written");
    stop_hold_a: assert property (r.stop && !cnt_rst |=> $stable(r.cnt))
        else $error("counter moved while stopped");
    cnt_rst_a: assert property (cnt_rst |=> r.cnt == 16'h0000)
        else $error("counter reset bit ignored");
    irq_gate_a: assert property (ch_irq[0] |-> r.ch[0].flag && r.ch[0].ie)
        else $error("channel interrupt without flag and enable");
    flag_w1_a: assert property (r.ch[1].flag && wr && addr == OFS_CH1_CTL |=> r.ch[1].flag || $past(r.ch[1].armed))
        else $error("flag cleared without arming read");
    buf_off_a: assert property (r.ch[0].msb |=> !pin_oe[1])
        else $error("channel 1 pin driven in buffered mode");
    preset_a: assert property (r.ch[0].els == ELS_OFF ##1 r.ch[0].els == ELS_OFF |=> pin_out[0] == !$past(r.ch[0].msa))
        else $error("preset level wrong");
    cap_blk_a: assert property (r.ch[0].hold && r.ch[0].els != ELS_OFF && !r.ch[0].msa && !r.ch[0].msb && !wr |=> $stable(r.ch[0].val))
        else $error("capture while high byte held");
endmodule // tcc_top
`default_nettype wire

// [pkg/tcc_pkg.sv]
// Package: registers, fields and state types of the timer capture/compare block
// Function
// - Modulo match sets overflow flag, restarts count
// - Upper modulo write blocks overflow flag till lower
// - Reset sets modulo value to all ones
// - Capture edge or compare match sets flag
// - Flag clears by read then write zero
// - Interrupt requested while enable and flag set; overflow interrupt also masked from upper till lower modulo write
// - Channel 0 buffering disables channel 1
// - Mode bit A picks compare or capture
// - Edge field 00 presets output from bit A
// - Capture edge from edge/level code
// - Compare action toggle, low or high
// - Preset level reaches pin once enabled
// - Toggle on overflow for compare channels
// - Overflow action beats same-cycle compare action
// - Max duty forces 100% when toggle on overflow is also set, from next period
// - Value register holds capture or compare value
// - Upper value read blocks captures till lower read
// - Upper value write blocks compares till lower write
// - Reset clears all channel control bits
// - Stop bit holds counter, inhibits capture
// - Counter reset bit clears counter, reads zero
`default_nettype none
package tcc_pkg;
    localparam logic [3:0] OFS_STATUS = 4'h0;
    localparam logic [3:0] OFS_CNT_H = 4'h1;
    localparam logic [3:0] OFS_CNT_L = 4'h2;
    localparam logic [3:0] OFS_MOD_H = 4'h3;
    localparam logic [3:0] OFS_MOD_L = 4'h4;
    localparam logic [3:0] OFS_CH0_CTL = 4'h5;
    localparam logic [3:0] OFS_CH0_H = 4'h6;
    localparam logic [3:0] OFS_CH0_L = 4'h7;
    localparam logic [3:0] OFS_CH1_CTL = 4'h8;
    localparam logic [3:0] OFS_CH1_H = 4'h9;
    localparam logic [3:0] OFS_CH1_L = 4'ha;
    // Status register bit positions
    localparam int unsigned ST_OVF = 7;
    localparam int unsigned ST_OVIE = 6;
    localparam int unsigned ST_STOP = 5;
    localparam int unsigned ST_CRST = 4;
    // Channel control bit positions; edge/level field at [3:2]
    localparam int unsigned CC_FLAG = 7;
    localparam int unsigned CC_IE = 6;
    localparam int unsigned CC_MSB = 5;
    localparam int unsigned CC_MSA = 4;
    localparam int unsigned CC_ELS = 2;
    localparam int unsigned CC_TOV = 1;
    localparam int unsigned CC_MAX = 0;
    localparam logic [15:0] MOD_RESET = 16'hffff;
    localparam logic STOP_RESET = 1'b1;
    localparam logic [1:0] ELS_OFF = 2'h0;
    localparam logic [1:0] ELS_A = 2'h1;
    localparam logic [1:0] ELS_B = 2'h2;

    typedef struct packed {
        logic flag;
        logic ie;
        logic msb;
        logic msa;
        logic [1:0] els;
        logic tov;
        logic max;
        logic armed;
        logic hold;
        logic outl;
        logic maxe;
        logic prev;
        logic [15:0] val;
    } tcc_ch_s;

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] modv;
        logic minh;
        logic stop;
        logic ovf;
        logic ovie;
        logic ovarm;
        logic act;
        logic lastw;
        tcc_ch_s [1:0] ch;
        logic [7:0] rdata;
        logic [1:0] irq;
        logic ovirq;
        logic [1:0] pout;
        logic [1:0] poe;
    } tcc_state_s;
endpackage : tcc_pkg
`default_nettype wire

// [sim/tcc_pin_model.sv]
// Pin-side model: external drivers and pull-ups on the two channel pins
`default_nettype none
module tcc_pin_model
(
    input wire logic [1:0] drv_en,
    input wire logic [1:0] drv_lvl,
    input wire logic [1:0] pin_out,
    input wire logic [1:0] pin_oe,
    output logic [1:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Wire level: outside driver first, then the block, else the pull-up
    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (drv_en[i])
                pin_in[i] = drv_lvl[i];
            else if (pin_oe[i])
                pin_in[i] = pin_out[i];
            else
                pin_in[i] = 1'b1;
        end
    end
endmodule // tcc_pin_model
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the timer capture/compare block
`default_nettype none
module testbench
    import tcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic tick = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [1:0] pin_in, pin_out, pin_oe, ch_irq;
    logic ovf_irq;
    logic [1:0] drv_en = 2'h0;
    logic [1:0] drv_lvl = 2'h0;
    logic [7:0] d;
    logic pre;
    int v;
    int n_errors = 0;
    int n_compared = 0;

    tcc_top dut (.clk(clk), .resetn(resetn), .tick(tick), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .ch_irq(ch_irq), .ovf_irq(ovf_irq));
    tcc_pin_model pins (.drv_en(drv_en), .drv_lvl(drv_lvl), .pin_out(pin_out),
        .pin_oe(pin_oe), .pin_in(pin_in));

    // 200 MHz clock
    always #2.5 clk = ~clk;

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] dat);
        @(posedge clk);
        addr <= a;
        wdata <= dat;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe; ending on a rising edge
    // keeps the next pin or strobe change on the edge as well
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask
    // A read while the flag is set arms the clearing write
    task automatic set_ctl(input logic [3:0] a, input logic [7:0] val);
        rd_reg(a);
        wr_reg(a, val);
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask
    function automatic logic exp_cap(input logic [1:0] els, input logic rise);
        return (els == ELS_A) ? rise : (els == ELS_B) ? ~rise : 1'b1;
    endfunction
    function automatic logic exp_cmp(input logic [1:0] els, input logic p);
        return (els == ELS_A) ? ~p : (els == ELS_B) ? 1'b0 : 1'b1;
    endfunction
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Watchdog: the whole sequence needs about 700 cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        test_done();
    end

    initial
    begin
        void'($urandom(19007));
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd_reg(OFS_MOD_H);
        chk("mod_h", 8'hff, d);
        rd_reg(OFS_MOD_L);
        chk("mod_l", 8'hff, d);
        rd_reg(OFS_CH0_CTL);
        chk("ch0 ctl", 8'h00, d);
        rd_reg(OFS_CH1_CTL);
        chk("ch1 ctl", 8'h00, d);
        rd_reg(OFS_STATUS);
        chk("stop", 8'h20, d & 8'h30);
        $display("test reset done");
        // Half-written modulo must not raise the flag
        tick <= 1'b1;
        wr_reg(OFS_STATUS, 8'h30);
        wr_reg(OFS_MOD_H, 8'h00);
        wr_reg(OFS_STATUS, 8'h10);
        cyc(300);
        rd_reg(OFS_STATUS);
        chk("ovf blocked", 8'h00, d & 8'h90);
        wr_reg(OFS_MOD_L, 8'h07);
        wr_reg(OFS_STATUS, 8'h10);
        cyc(12);
        rd_reg(OFS_STATUS);
        chk("ovf set", 8'h80, d & 8'h90);
        rd_reg(OFS_CNT_H);
        chk("cnt_h", 8'h00, d);
        rd_reg(OFS_CNT_L);
        chk("cnt_l", 8'h00, d & 8'hf8);
        $display("test modulo done");
        // Every edge code against both edge directions
        drv_en <= 2'h1;
        for (int e = 1; e < 4; e++)
        begin
            for (int r = 0; r < 2; r++)
            begin
                drv_lvl[0] <= ~r[0];
                cyc(3);
                set_ctl(OFS_CH0_CTL, {4'h4, e[1:0], 2'h0});
                drv_lvl[0] <= r[0];
                cyc(3);
                rd_reg(OFS_CH0_CTL);
                chk("cap flag", {7'h0, exp_cap(e[1:0], r[0])}, {7'h0, d[CC_FLAG]});
                chk("ch0 irq", {7'h0, exp_cap(e[1:0], r[0])}, {7'h0, ch_irq[0]});
            end
        end
        $display("test capture done");
        // Fresh event between arming read and clearing write wins
        drv_lvl[0] <= 1'b0;
        cyc(3);
        wr_reg(OFS_CH0_CTL, 8'h4c);
        rd_reg(OFS_CH0_CTL);
        chk("clear after event", 8'hcc, d);
        wr_reg(OFS_CH0_CTL, 8'h4c);
        rd_reg(OFS_CH0_CTL);
        chk("clear armed", 8'h4c, d);
        chk("irq off", 8'h00, {7'h0, ch_irq[0]});
        wr_reg(OFS_CH0_CTL, 8'hcc);
        rd_reg(OFS_CH0_CTL);
        chk("write one", 8'h4c, d);
        rd_reg(OFS_CH0_H);
        drv_lvl[0] <= 1'b1;
        cyc(3);
        rd_reg(OFS_CH0_CTL);
        chk("cap blocked", 8'h4c, d);
        rd_reg(OFS_CH0_L);
        chk("cap value", 8'h00, d & 8'hf8);
        drv_lvl[0] <= 1'b0;
        cyc(3);
        rd_reg(OFS_CH0_CTL);
        chk("cap resumed", 8'hcc, d);
        $display("test flag done");
        // Compare actions on channel 1 from an opposite preset
        drv_en <= 2'h0;
        for (int e = 1; e < 4; e++)
        begin
            pre = (e != 3);
            v = 2 + $urandom % 4;
            wr_reg(OFS_STATUS, 8'h30);
            set_ctl(OFS_CH1_CTL, {3'h0, ~pre, 4'h0});
            cyc(2);
            chk("preset", {6'h0, 1'b0, pre}, {6'h0, pin_oe[1], pin_out[1]});
            wr_reg(OFS_CH1_H, 8'h00);
            wr_reg(OFS_CH1_L, v[7:0]);
            wr_reg(OFS_CH1_CTL, {4'h1, e[1:0], 2'h0});
            cyc(2);
            chk("enabled", {6'h0, 1'b1, pre}, {6'h0, pin_oe[1], pin_out[1]});
            wr_reg(OFS_STATUS, 8'h00);
            cyc(8);
            chk("cmp out", {7'h0, exp_cmp(e[1:0], pre)}, {7'h0, pin_out[1]});
            rd_reg(OFS_CH1_CTL);
            chk("cmp flag", 8'h80, d & 8'h80);
        end
        // Upper value write blocks compares till the lower write; stop keeps a match out between arming read and clear
        wr_reg(OFS_STATUS, 8'h30);
        set_ctl(OFS_CH1_CTL, 8'h1c);
        wr_reg(OFS_CH1_H, 8'h00);
        wr_reg(OFS_STATUS, 8'h00);
        cyc(20);
        rd_reg(OFS_CH1_CTL);
        chk("cmp blocked", 8'h1c, d);
        wr_reg(OFS_CH1_L, 8'h03);
        cyc(10);
        rd_reg(OFS_CH1_CTL);
        chk("cmp resumed", 8'h9c, d);
        $display("test compare done");
        // Match on the modulo value sets high, so a low pin shows the toggle won
        wr_reg(OFS_STATUS, 8'h30);
        set_ctl(OFS_CH1_CTL, 8'h00);
        wr_reg(OFS_CH1_L, 8'h07);
        wr_reg(OFS_CH1_CTL, 8'h1e);
        wr_reg(OFS_STATUS, 8'h00);
        cyc(10);
        chk("ovf wins", 8'h00, {7'h0, pin_out[1]});
        cyc(8);
        chk("ovf toggle", 8'h01, {7'h0, pin_out[1]});
        wr_reg(OFS_CH1_CTL, 8'h1f);
        cyc(20);
        for (int i = 0; i < 8; i++)
        begin
            cyc(1);
            chk("max duty", 8'h01, {7'h0, pin_out[1]});
        end
        // Buffered select takes channel 1 off its pin
        wr_reg(OFS_CH0_CTL, 8'h24);
        wr_reg(OFS_CH1_CTL, 8'h1c);
        cyc(2);
        chk("pin owners", 8'h01, {6'h0, pin_oe});
        rd_reg(OFS_CH1_CTL);
        chk("ch1 locked", 8'h1f, d & 8'h7f);
        $display("test overflow done");
        test_done();
    end
endmodule // testbench
`default_nettype wire
